// file: rlpc_pkg.sv
// package: constants for the reset and low-power controller
package rlpc_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] RLPC_OFS_CTRL = 8'h00;
    localparam logic [7:0] RLPC_OFS_SERVICE = 8'h04;
    localparam logic [7:0] RLPC_OFS_STATUS = 8'h08;
    localparam logic [7:0] RLPC_OFS_CAUSE = 8'h0C;
    // ctrl fields and reset value
    localparam int RLPC_CTRL_WDEN_BIT = 0;
    localparam logic [31:0] RLPC_CTRL_RESET = 32'h0000_0000;
    // watchdog service sequence: first key then second key
    localparam logic [7:0] RLPC_WD_KEY1 = 8'h55;
    localparam logic [7:0] RLPC_WD_KEY2 = 8'hAA;
    // watchdog timeout in sub oscillator ticks
    localparam logic [15:0] RLPC_WD_TIMEOUT_TICKS = 16'h1000;
    // status fields
    localparam int RLPC_ST_SELFCHECK_BIT = 0;
    localparam int RLPC_ST_LP_LSB = 1;
    localparam int RLPC_ST_STAB_BIT = 3;
    // cause fields (write one to clear)
    localparam int RLPC_CA_EXT_BIT = 0;
    localparam int RLPC_CA_POR_BIT = 1;
    localparam int RLPC_CA_WD_BIT = 2;
    localparam int RLPC_CA_ILL_BIT = 3;
    // oscillator stabilization delay in main oscillator cycles
    localparam int unsigned RLPC_STAB_CYCLES = 8192;
    localparam int RLPC_STAB_W = 16;
    // minimum length of a reset caused by a one-cycle internal event
    localparam logic [2:0] RLPC_INT_RST_CYCLES = 3'h4;
    // address map used by the illegal-fetch and test-rom fetch checks
    localparam logic [15:0] RLPC_IO_END = 16'h003F;
    localparam logic [15:0] RLPC_RAM_START = 16'h0040;
    localparam logic [15:0] RLPC_RAM_END = 16'h023F;
    localparam logic [15:0] RLPC_ROM_START = 16'h1000;
    localparam logic [15:0] RLPC_ROM_END = 16'hFFFF;
    localparam logic [15:0] RLPC_TEST_START = 16'hFE00;
    localparam logic [15:0] RLPC_TEST_END = 16'hFFDF;

    typedef enum logic [1:0] {
        RLPC_RUN,
        RLPC_WAIT,
        RLPC_STOP,
        RLPC_STAB
    } rlpc_lp_t;
endpackage : rlpc_pkg

// file: rlpc_stab_counter.sv
// oscillator stabilization delay counter
`timescale 1ns/1ps
`default_nettype none
module rlpc_stab_counter #(
    parameter int unsigned CYCLES = rlpc_pkg::RLPC_STAB_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic start,
    output logic busy
);
    import rlpc_pkg::*;

    logic [RLPC_STAB_W-1:0] count_reg;
    logic [RLPC_STAB_W-1:0] count_next;
    logic busy_reg;
    logic busy_next;
    localparam logic [RLPC_STAB_W-1:0] LAST = RLPC_STAB_W'(CYCLES - 1);

    always_comb begin
        count_next = count_reg;
        busy_next = busy_reg;
        if (start) begin
            count_next = '0;
            busy_next = 1'b1;
        end else if (busy_reg) begin
            if (count_reg == LAST) begin
                busy_next = 1'b0;
            end else begin
                count_next = count_reg + 1'b1;
            end
        end
    end

    // power-up counts from reset release, so busy starts high
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count_reg <= '0;
            busy_reg <= 1'b1;
        end else begin
            count_reg <= count_next;
            busy_reg <= busy_next;
        end
    end

    assign busy = busy_reg;
endmodule : rlpc_stab_counter
`default_nettype wire

// file: rlpc_top.sv
// reset merge, mode latch, watchdog and stop/wait sequencing with apb registers
//
// Overview of operation
// [RULE1] four reset sources are ORed into one latch, registered on the bus clock
// [RULE2] the synchronous reset drives both the peripheral and core reset outputs
// [RULE3] a low external reset pin holds reset until the pin is high again
// [RULE4] power-on holds reset for the oscillator stabilization count
// [RULE5] after the power-on delay, reset stays while any other source is active
// [RULE6] an enabled watchdog not serviced before timeout raises an internal reset
// [RULE7] opcode fetches from unused or i/o addresses raise an illegal-address reset
// [RULE8] illegal-address reset keeps the current operating mode, pins not resampled
// [RULE9] mode is latched at external reset rise: bit7 low, bit6 high, test vpp
// [RULE10] self-check mode runs the test program at FE00 through FFDF
// [RULE11] stop turns the main oscillator off; sub oscillator watchdog keeps counting
// [RULE12] stop entry clears the timer prescaler and removes and disables timer irqs
// [RULE13] stop entry clears the interrupt mask; everything else is left alone
// [RULE14] stop ends only on reset or the five listed wake-up interrupts
// [RULE15] wait halts the processor only; any interrupt or reset ends it
// [RULE16] wait entry clears the interrupt mask; everything else is left alone
// [RULE17] software must leave wait and service the watchdog before timeout
// [RULE18] stop wake-up restarts the oscillator and waits the stabilization count
`timescale 1ns/1ps
`default_nettype none
module rlpc_top #(
    parameter int unsigned STAB_CYCLES = rlpc_pkg::RLPC_STAB_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic externalResetN,
    input wire logic portCBit7,
    input wire logic portCBit6,
    input wire logic vppTestLevel,
    input wire logic opcodeFetch,
    input wire logic [15:0] fetchAddr,
    input wire logic subOscTick,
    input wire logic stopInstr,
    input wire logic waitInstr,
    input wire logic externalInterrupt1,
    input wire logic externalInterrupt2,
    input wire logic keyWakeupInterrupt,
    input wire logic pdWakeupInterrupt,
    input wire logic rtcInterrupt,
    input wire logic anyInterrupt,
    output logic peripheralReset,
    output logic coreReset,
    output logic selfCheckMode,
    output logic testRomFetch,
    output logic mainOscillatorEnable,
    output logic cpuHalt,
    output logic timerHalt,
    output logic clearIntMask,
    output logic clearTimerPrescaler,
    output logic timerIrqDisable
);
    import rlpc_pkg::*;

    function automatic logic isIllegal(input logic [15:0] a);
        logic ok;
        ok = (a >= RLPC_RAM_START && a <= RLPC_RAM_END) || (a >= RLPC_ROM_START && a <= RLPC_ROM_END);
        isIllegal = !ok || (a <= RLPC_IO_END);
    endfunction : isIllegal

    function automatic logic inTestRom(input logic [15:0] a);
        inTestRom = (a >= RLPC_TEST_START) && (a <= RLPC_TEST_END);
    endfunction : inTestRom

    ////////////////////////////////////////////////////////////////////////////
    // state declarations
    logic resetLatch_reg, resetLatch_next;
    logic syncReset_reg, syncReset_next;
    logic [2:0] stretch_reg, stretch_next;
    logic extPinPrev_reg, extPinPrev_next;
    logic selfCheck_reg, selfCheck_next;
    logic testFetch_reg, testFetch_next;
    logic wdEnable_reg, wdEnable_next;
    logic wdKeyArmed_reg, wdKeyArmed_next;
    logic [15:0] wdCount_reg, wdCount_next;
    logic wdFire_reg, wdFire_next;
    logic [3:0] cause_reg, cause_next;
    rlpc_lp_t lp_reg, lp_next;
    logic oscEn_reg, oscEn_next;
    logic cpuHalt_reg, cpuHalt_next;
    logic timerHalt_reg, timerHalt_next;
    logic clrMask_reg, clrMask_next;
    logic clrPresc_reg, clrPresc_next;
    logic tmrDis_reg, tmrDis_next;
    logic stabStart_reg, stabStart_next;
    logic pready_reg, pready_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pslverr_reg, pslverr_next;
    logic porBusy_reg, porBusy_next;
    logic stabBusy;
    logic illegalFetch;
    logic wrDone;
    logic stopWake;

    rlpc_stab_counter #(
        .CYCLES(STAB_CYCLES)
    ) u_stab (
        .clk(clk),
        .rstn(rstn),
        .start(stabStart_reg),
        .busy(stabBusy)
    );

    assign illegalFetch = opcodeFetch && !syncReset_reg && isIllegal(fetchAddr); // RULE7
    assign wrDone = psel && penable && pready_reg && pwrite;
    assign stopWake = externalInterrupt1 || externalInterrupt2 || keyWakeupInterrupt
        || pdWakeupInterrupt || rtcInterrupt; // RULE14

    ////////////////////////////////////////////////////////////////////////////
    // reset merge
    always_comb begin
        stretch_next = stretch_reg;
        if (illegalFetch || wdFire_reg) begin
            stretch_next = RLPC_INT_RST_CYCLES;
        end else if (stretch_reg != 3'h0) begin
            stretch_next = stretch_reg - 3'h1;
        end
        porBusy_next = porBusy_reg && stabBusy;
        // any source sets the latch; it drops only when every source is gone
        resetLatch_next = !externalResetN || porBusy_next || (stretch_next != 3'h0); // RULE1 RULE3 RULE4 RULE5
        syncReset_next = resetLatch_reg; // RULE1
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stretch_reg <= 3'h0;
            porBusy_reg <= 1'b1;
            resetLatch_reg <= 1'b1;
            syncReset_reg <= 1'b1;
        end else begin
            stretch_reg <= stretch_next;
            porBusy_reg <= porBusy_next;
            resetLatch_reg <= resetLatch_next;
            syncReset_reg <= syncReset_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // operating mode latch
    always_comb begin
        extPinPrev_next = externalResetN;
        selfCheck_next = selfCheck_reg;
        // only the pin's rising edge samples, so internal resets keep the mode
        if (externalResetN && !extPinPrev_reg) begin // RULE8
            selfCheck_next = !portCBit7 && portCBit6 && vppTestLevel; // RULE9
        end
        testFetch_next = selfCheck_reg && opcodeFetch && inTestRom(fetchAddr); // RULE10
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            extPinPrev_reg <= 1'b0;
            selfCheck_reg <= 1'b0;
            testFetch_reg <= 1'b0;
        end else begin
            extPinPrev_reg <= extPinPrev_next;
            selfCheck_reg <= selfCheck_next;
            testFetch_reg <= testFetch_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // watchdog and cause flags
    always_comb begin
        wdEnable_next = wdEnable_reg;
        wdKeyArmed_next = wdKeyArmed_reg;
        wdCount_next = wdCount_reg;
        wdFire_next = 1'b0;
        cause_next = cause_reg;
        if (wrDone && paddr == RLPC_OFS_CTRL) begin
            wdEnable_next = pwdata[RLPC_CTRL_WDEN_BIT];
        end
        if (wrDone && paddr == RLPC_OFS_SERVICE) begin
            if (pwdata[7:0] == RLPC_WD_KEY1) begin
                wdKeyArmed_next = 1'b1;
            end else if (pwdata[7:0] == RLPC_WD_KEY2 && wdKeyArmed_reg) begin
                wdKeyArmed_next = 1'b0;
                wdCount_next = 16'h0000;
            end else begin
                wdKeyArmed_next = 1'b0;
            end
        end
        // sub oscillator ticks continue through stop and wait
        if (wdEnable_reg && subOscTick) begin // RULE11 RULE17
            if (wdCount_reg == RLPC_WD_TIMEOUT_TICKS - 16'h1) begin
                wdFire_next = 1'b1; // RULE6
                wdCount_next = 16'h0000;
            end else begin
                wdCount_next = wdCount_reg + 16'h1;
            end
        end
        if (syncReset_reg) begin
            wdEnable_next = RLPC_CTRL_RESET[RLPC_CTRL_WDEN_BIT];
            wdKeyArmed_next = 1'b0;
            wdCount_next = 16'h0000;
            wdFire_next = 1'b0;
        end
        if (wrDone && paddr == RLPC_OFS_CAUSE) begin
            cause_next = cause_reg & ~pwdata[3:0];
        end
        // set wins over a clear in the same cycle
        if (!externalResetN) cause_next[RLPC_CA_EXT_BIT] = 1'b1;
        if (wdFire_reg) cause_next[RLPC_CA_WD_BIT] = 1'b1;
        if (illegalFetch) cause_next[RLPC_CA_ILL_BIT] = 1'b1;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wdEnable_reg <= 1'b0;
            wdKeyArmed_reg <= 1'b0;
            wdCount_reg <= 16'h0000;
            wdFire_reg <= 1'b0;
            cause_reg <= 4'h2;
        end else begin
            wdEnable_reg <= wdEnable_next;
            wdKeyArmed_reg <= wdKeyArmed_next;
            wdCount_reg <= wdCount_next;
            wdFire_reg <= wdFire_next;
            cause_reg <= cause_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // stop and wait sequencing
    always_comb begin
        lp_next = lp_reg;
        clrMask_next = 1'b0;
        clrPresc_next = 1'b0;
        tmrDis_next = 1'b0;
        stabStart_next = 1'b0;
        unique case (lp_reg)
            RLPC_RUN: begin
                if (!syncReset_reg && stopInstr) begin
                    lp_next = RLPC_STOP;
                    clrPresc_next = 1'b1; // RULE12
                    tmrDis_next = 1'b1; // RULE12
                    clrMask_next = 1'b1; // RULE13
                end else if (!syncReset_reg && waitInstr) begin
                    lp_next = RLPC_WAIT;
                    clrMask_next = 1'b1; // RULE16
                end
            end
            RLPC_WAIT: begin
                if (anyInterrupt || syncReset_reg) begin // RULE15
                    lp_next = RLPC_RUN;
                end
            end
            RLPC_STOP: begin
                // oscillator must settle again before the core resumes
                if (stopWake || syncReset_reg) begin // RULE14
                    lp_next = RLPC_STAB;
                    stabStart_next = 1'b1; // RULE18
                end
            end
            RLPC_STAB: begin
                if (!stabStart_reg && !stabBusy) begin // RULE18
                    lp_next = RLPC_RUN;
                end
            end
        endcase
        oscEn_next = (lp_next != RLPC_STOP); // RULE11
        cpuHalt_next = (lp_next != RLPC_RUN); // RULE15
        timerHalt_next = (lp_next == RLPC_STOP) || (lp_next == RLPC_STAB); // RULE11
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lp_reg <= RLPC_RUN;
            oscEn_reg <= 1'b1;
            cpuHalt_reg <= 1'b0;
            timerHalt_reg <= 1'b0;
            clrMask_reg <= 1'b0;
            clrPresc_reg <= 1'b0;
            tmrDis_reg <= 1'b0;
            stabStart_reg <= 1'b0;
        end else begin
            lp_reg <= lp_next;
            oscEn_reg <= oscEn_next;
            cpuHalt_reg <= cpuHalt_next;
            timerHalt_reg <= timerHalt_next;
            clrMask_reg <= clrMask_next;
            clrPresc_reg <= clrPresc_next;
            tmrDis_reg <= tmrDis_next;
            stabStart_reg <= stabStart_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, answer registered
    always_comb begin
        pready_next = 1'b0;
        prdata_next = prdata_reg;
        pslverr_next = 1'b0;
        if (psel && penable && !pready_reg) begin
            pready_next = 1'b1;
            prdata_next = 32'h0000_0000;
            unique case (paddr)
                RLPC_OFS_CTRL: prdata_next[RLPC_CTRL_WDEN_BIT] = wdEnable_reg;
                RLPC_OFS_SERVICE: prdata_next = 32'h0000_0000;
                RLPC_OFS_STATUS: begin
                    prdata_next[RLPC_ST_SELFCHECK_BIT] = selfCheck_reg;
                    prdata_next[RLPC_ST_LP_LSB +: 2] = lp_reg;
                    prdata_next[RLPC_ST_STAB_BIT] = stabBusy;
                end
                RLPC_OFS_CAUSE: prdata_next[3:0] = cause_reg;
                default: pslverr_next = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= pready_next;
            prdata_reg <= prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign pready = pready_reg;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;
    assign peripheralReset = syncReset_reg; // RULE2
    assign coreReset = syncReset_reg; // RULE2
    assign selfCheckMode = selfCheck_reg;
    assign testRomFetch = testFetch_reg;
    assign mainOscillatorEnable = oscEn_reg;
    assign cpuHalt = cpuHalt_reg;
    assign timerHalt = timerHalt_reg;
    assign clearIntMask = clrMask_reg;
    assign clearTimerPrescaler = clrPresc_reg;
    assign timerIrqDisable = tmrDis_reg;
endmodule : rlpc_top
`default_nettype wire

// file: rlpc_props.sv
// checker: reset, mode and low-power timing relations at the top ports
`timescale 1ns/1ps
`default_nettype none
module rlpc_props #(
    parameter int unsigned STAB_CYCLES = rlpc_pkg::RLPC_STAB_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic externalResetN,
    input wire logic portCBit7,
    input wire logic portCBit6,
    input wire logic vppTestLevel,
    input wire logic opcodeFetch,
    input wire logic [15:0] fetchAddr,
    input wire logic stopInstr,
    input wire logic waitInstr,
    input wire logic externalInterrupt1,
    input wire logic externalInterrupt2,
    input wire logic keyWakeupInterrupt,
    input wire logic pdWakeupInterrupt,
    input wire logic rtcInterrupt,
    input wire logic anyInterrupt,
    input wire logic peripheralReset,
    input wire logic coreReset,
    input wire logic selfCheckMode,
    input wire logic testRomFetch,
    input wire logic mainOscillatorEnable,
    input wire logic cpuHalt,
    input wire logic timerHalt,
    input wire logic clearIntMask,
    input wire logic clearTimerPrescaler,
    input wire logic timerIrqDisable
);
    import rlpc_pkg::*;
    logic wakeAny;
    logic [15:0] relCnt_reg;
    logic [15:0] relCnt_next;
    assign wakeAny = externalInterrupt1 | externalInterrupt2 | keyWakeupInterrupt | pdWakeupInterrupt | rtcInterrupt;
    // saturates so a long run never wraps back into the power-on window
    always_comb begin
        relCnt_next = relCnt_reg;
        if (relCnt_reg != 16'hFFFF) relCnt_next = relCnt_reg + 16'h0001;
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) relCnt_reg <= 16'h0000;
        else relCnt_reg <= relCnt_next;
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence stopEntry;
        stopInstr && !cpuHalt && !peripheralReset;
    endsequence
    sequence stopState;
        !mainOscillatorEnable && timerHalt && cpuHalt && clearTimerPrescaler && timerIrqDisable && clearIntMask;
    endsequence
    reset_pair_a: assert property (peripheralReset == coreReset)
        else $error("core and peripheral resets differ");
    por_hold_a: assert property (32'(relCnt_reg) < STAB_CYCLES |-> peripheralReset)
        else $error("reset dropped inside the power-on delay");
    pin_hold_a: assert property (!externalResetN ##1 !externalResetN |-> ##1 peripheralReset)
        else $error("reset low while the pin is held low");
    stop_entry_a: assert property (stopEntry |=> stopState)
        else $error("stop entry outputs wrong");
    wait_entry_a: assert property (waitInstr && !stopInstr && !cpuHalt && !peripheralReset |=>
        cpuHalt && clearIntMask && mainOscillatorEnable && !timerHalt && !clearTimerPrescaler)
        else $error("wait entry outputs wrong");
    stop_wake_a: assert property (!mainOscillatorEnable && wakeAny && !peripheralReset |=>
        (mainOscillatorEnable && cpuHalt) ##1 cpuHalt [*7]) else $error("stop wake without stabilization");
    stop_exit_a: assert property ($rose(mainOscillatorEnable) |-> $past(wakeAny) or ##[0:3] peripheralReset)
        else $error("oscillator restarted without wake source or reset");
    wait_exit_a: assert property (cpuHalt && !timerHalt && anyInterrupt && !peripheralReset |=> !cpuHalt)
        else $error("interrupt did not end wait");
    test_fetch_a: assert property (opcodeFetch && selfCheckMode && fetchAddr >= RLPC_TEST_START &&
        fetchAddr <= RLPC_TEST_END && !peripheralReset |=> testRomFetch) else $error("test program fetch missed");
    mode_latch_a: assert property ($rose(externalResetN) |->
        ##[1:3] (selfCheckMode == (!portCBit7 && portCBit6 && vppTestLevel))) else $error("mode not latched");
endmodule : rlpc_props

bind rlpc_top rlpc_props #(.STAB_CYCLES(STAB_CYCLES)) props (.clk, .rstn, .externalResetN, .portCBit7, .portCBit6,
    .vppTestLevel, .opcodeFetch, .fetchAddr, .stopInstr, .waitInstr, .externalInterrupt1, .externalInterrupt2,
    .keyWakeupInterrupt, .pdWakeupInterrupt, .rtcInterrupt, .anyInterrupt, .peripheralReset, .coreReset,
    .selfCheckMode, .testRomFetch, .mainOscillatorEnable, .cpuHalt, .timerHalt, .clearIntMask,
    .clearTimerPrescaler, .timerIrqDisable);
`default_nettype wire

// file: rlpc_ext_model.sv
// partner model: external reset pin and mode strap levels
`timescale 1ns/1ps
`default_nettype none
module rlpc_ext_model (
    input wire logic clk,
    output logic externalResetN,
    output logic portCBit7,
    output logic portCBit6,
    output logic vppTestLevel
);
    initial begin
        externalResetN = 1'b1;
        {portCBit7, portCBit6, vppTestLevel} = 3'h4;
    end
    // straps kept after the rise so the mode latch never sees them move
    task automatic pulse(input logic [2:0] straps, input int lowCycles);
        @(posedge clk);
        externalResetN <= 1'b0;
        {portCBit7, portCBit6, vppTestLevel} <= straps;
        repeat (lowCycles) @(posedge clk);
        externalResetN <= 1'b1;
    endtask : pulse
endmodule : rlpc_ext_model
`default_nettype wire

// file: rlpc_top_test.sv
// testbench: reset sources, mode straps, watchdog and stop/wait sequencing
`timescale 1ns/1ps
`default_nettype none
module rlpc_top_test;
    import rlpc_pkg::*;
    localparam int unsigned STAB = 16;
    logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, opcodeFetch = 1'b0, subOscTick = 1'b0, stopInstr = 1'b0, waitInstr = 1'b0;
    logic anyInterrupt = 1'b0, externalResetN, portCBit7, portCBit6, vppTestLevel;
    logic [15:0] fetchAddr = 16'h0000;
    logic [4:0] wake = 5'h00;
    logic peripheralReset, coreReset, selfCheckMode, testRomFetch, mainOscillatorEnable, cpuHalt, timerHalt;
    logic clearIntMask, clearTimerPrescaler, timerIrqDisable;
    logic [15:0] adr [5] = '{16'h0100, 16'h2000, 16'hFE10, 16'h0010, 16'h0300};
    logic ill [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    int errors = 0, n_tests = 0, k;
    always #5 clk = ~clk;
    rlpc_ext_model ext (.clk, .externalResetN, .portCBit7, .portCBit6, .vppTestLevel);
    rlpc_top #(.STAB_CYCLES(STAB)) DUT (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr, .externalResetN, .portCBit7, .portCBit6, .vppTestLevel, .opcodeFetch, .fetchAddr, .subOscTick,
        .stopInstr, .waitInstr, .externalInterrupt1(wake[0]), .externalInterrupt2(wake[1]),
        .keyWakeupInterrupt(wake[2]), .pdWakeupInterrupt(wake[3]), .rtcInterrupt(wake[4]), .anyInterrupt,
        .peripheralReset, .coreReset, .selfCheckMode, .testRomFetch, .mainOscillatorEnable, .cpuHalt, .timerHalt,
        .clearIntMask, .clearTimerPrescaler, .timerIrqDisable);
    ////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n == 20) begin
            errors++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // bounded wait for the synchronous reset to reach level v
    task automatic waitFor(input logic v, output int c);
        c = 0;
        while (peripheralReset !== v && c < 1000) begin
            @(posedge clk);
            c++;
        end
        if (c == 1000) begin
            errors++;
            tally_and_finish();
        end
    endtask : waitFor
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            subOscTick <= 1'b1;
            @(posedge clk);
            subOscTick <= 1'b0;
        end
    endtask : tick
    task automatic strobe(input logic f, input logic s, input logic w, input logic [15:0] a);
        @(posedge clk);
        {opcodeFetch, stopInstr, waitInstr, fetchAddr} <= {f, s, w, a};
        @(posedge clk);
        {opcodeFetch, stopInstr, waitInstr} <= 3'h0;
    endtask : strobe
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        waitFor(1'b0, k);
        chk("power-on length", 1, 32'(k >= STAB && k <= STAB + 4));
        apb(1'b0, RLPC_OFS_CTRL, 32'h0);
        chk("ctrl reset value", RLPC_CTRL_RESET, rd);
        apb(1'b1, 8'h10, 32'h1);
        chk("unmapped error", 1, 32'(err));
        $display("test power-on done");
        for (int i = 0; i < 8; i++) begin
            ext.pulse(i[2:0], 4);
            waitFor(1'b0, k);
            chk("mode for straps", 32'(i == 3), 32'(selfCheckMode));
        end
        $display("test mode straps done");
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        ext.pulse(3'h3, STAB + 6);
        chk("reset kept by pin", 1, 32'(peripheralReset));
        waitFor(1'b0, k);
        chk("release after pin", 1, 32'(k >= 1 && k <= 4));
        apb(1'b0, RLPC_OFS_CAUSE, 32'h0);
        chk("cause bits", 32'h3, rd & 32'hF);
        $display("test pin over power-on done");
        for (int i = 0; i < 5; i++) begin
            strobe(1'b1, 1'b0, 1'b0, adr[i]);
            k = 0;
            repeat (10) begin
                @(posedge clk);
                if (peripheralReset === 1'b1) k = 1;
            end
            chk("fetch reset", 32'(ill[i]), k);
            waitFor(1'b0, k);
            chk("mode kept", 1, 32'(selfCheckMode));
        end
        $display("test illegal fetch done");
        apb(1'b1, RLPC_OFS_CTRL, 32'h1);
        tick(4095);
        apb(1'b1, RLPC_OFS_SERVICE, 32'(RLPC_WD_KEY1));
        apb(1'b1, RLPC_OFS_SERVICE, 32'(RLPC_WD_KEY2));
        tick(4095);
        chk("no early watchdog", 0, 32'(peripheralReset));
        tick(1);
        waitFor(1'b1, k);
        chk("watchdog fire delay", 1, 32'(k <= 8));
        waitFor(1'b0, k);
        apb(1'b0, RLPC_OFS_CAUSE, 32'h0);
        chk("watchdog cause", 1, 32'(rd[RLPC_CA_WD_BIT]));
        $display("test watchdog done");
        for (int i = 0; i < 5; i++) begin
            strobe(1'b0, 1'b1, 1'b0, 16'h0000);
            anyInterrupt <= 1'b1;
            repeat (3) @(posedge clk);
            chk("stop holds", 32'h0, 32'({mainOscillatorEnable, ~timerHalt}));
            anyInterrupt <= 1'b0;
            wake <= 5'h01 << i;
            @(posedge clk);
            wake <= 5'h00;
            k = 0;
            while (cpuHalt !== 1'b0 && k < 200) begin
                @(posedge clk);
                k++;
            end
            chk("stop recovery", 1, 32'(k >= STAB - 2 && k <= STAB + 4));
        end
        $display("test stop done");
        strobe(1'b0, 1'b0, 1'b1, 16'h0000);
        @(posedge clk);
        chk("wait halts", 32'h3, 32'({cpuHalt, mainOscillatorEnable}));
        anyInterrupt <= 1'b1;
        @(posedge clk);
        anyInterrupt <= 1'b0;
        @(posedge clk);
        chk("wait ends", 0, 32'(cpuHalt));
        $display("test wait done");
        tally_and_finish();
    end
endmodule : rlpc_top_test
`default_nettype wire
